// ===== isd_pkg.sv
// Constants, types and helpers shared by the instruction subset decoder.
package isd_pkg;

  localparam int ISD_OSC_PER_TCY = 4;
  localparam logic [1:0] ISD_Q_FETCH = 2'h0;
  localparam logic [1:0] ISD_Q_MEM = 2'h1;
  localparam logic [1:0] ISD_Q_LAST = 2'(ISD_OSC_PER_TCY - 1);

  localparam logic [14:0] ISD_PC_RST = 15'h0000;
  localparam logic [15:0] ISD_PTR_RST = 16'h0000;

  localparam logic [13:0] M_EXACT = 14'h3FFF;
  localparam logic [13:0] M_LOW3 = 14'h3FF8;
  localparam logic [13:0] M_BRA = 14'h3E00;
  localparam logic [13:0] M_JMP = 14'h3800;
  localparam logic [13:0] M_LIT8 = 14'h3F00;
  localparam logic [13:0] M_K6 = 14'h3F80;

  localparam logic [13:0] OP_NOP = 14'h0000;
  localparam logic [13:0] OP_RESET = 14'h0001;
  localparam logic [13:0] OP_RETURN = 14'h0008;
  localparam logic [13:0] OP_INTERRUPT_RETURN = 14'h0009;
  localparam logic [13:0] OP_ACCUMULATOR_SUBROUTINE_CALL = 14'h000A;
  localparam logic [13:0] OP_BRW = 14'h000B;
  localparam logic [13:0] OP_OPTION = 14'h0062;
  localparam logic [13:0] OP_SLEEP = 14'h0063;
  localparam logic [13:0] OP_WATCHDOG_CLEAR_OP = 14'h0064;
  localparam logic [13:0] OP_DIRECTION_LOAD_OP = 14'h0060;
  localparam logic [13:0] OP_MOD_RD = 14'h0010;
  localparam logic [13:0] OP_MOD_WR = 14'h0018;
  localparam logic [13:0] OP_BRA = 14'h3200;
  localparam logic [13:0] OP_CALL = 14'h2000;
  localparam logic [13:0] OP_GOTO = 14'h2800;
  localparam logic [13:0] OP_RETURN_WITH_LITERAL = 14'h3400;
  localparam logic [13:0] OP_ADD_PTR = 14'h3100;
  localparam logic [13:0] OP_IDX_RD = 14'h3F00;
  localparam logic [13:0] OP_IDX_WR = 14'h3F80;

  // Flag values written by standby entry and watchdog clear
  localparam logic SLEEP_EXPIRY = 1'b1;
  localparam logic SLEEP_PD = 1'b0;
  localparam logic WATCHDOG_CLEAR_OP_EXPIRY = 1'b1;
  localparam logic WATCHDOG_CLEAR_OP_PD = 1'b1;

  typedef enum logic [1:0] {
    ISD_EXEC  = 2'b00,
    ISD_FLUSH = 2'b01,
    ISD_EXTRA = 2'b10
  } isd_seq_e;

  typedef enum logic [1:0] {
    ISD_PM_NONE = 2'b00,
    ISD_PM_ADD  = 2'b01,
    ISD_PM_MOD  = 2'b10,
    ISD_PM_IDX  = 2'b11
  } isd_pmode_e;

  function automatic logic isd_match(input logic [13:0] w, input logic [13:0] p,
                                     input logic [13:0] m);
    return (w & m) == p;
  endfunction

  function automatic logic [15:0] isd_sext6(input logic [5:0] k);
    return {{10{k[5]}}, k};
  endfunction

endpackage

// ===== isd_ptr_if.sv
// Control and result signals between the decoder and its pointer unit.
`timescale 1ns/1ps
interface isd_ptr_if;
  logic               sel;
  isd_pkg::isd_pmode_e mode;
  logic [1:0]         mm;
  logic [5:0]         k6;
  logic               commit;
  logic [15:0]        addr;
  logic [15:0]        ptr0;
  logic [15:0]        ptr1;

  modport ctrl (output sel, mode, mm, k6, commit, input addr, ptr0, ptr1);
  modport unit (input sel, mode, mm, k6, commit, output addr, ptr0, ptr1);
endinterface

// ===== isd_ptr_unit.sv
// Two indirect pointers with address generation and update arithmetic.
`timescale 1ns/1ps
module isd_ptr_unit (
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  // Decoder side
  isd_ptr_if.unit   bus
);

  logic [15:0] ptr_reg [0:1];
  logic [15:0] base;
  logic [15:0] sum;
  logic [15:0] step;
  logic [15:0] new_val;

  assign base = bus.sel ? ptr_reg[1] : ptr_reg[0];
  // Sixteen-bit sums drop the carry, so pointers roll over at both ends
  assign sum  = base + isd_pkg::isd_sext6(bus.k6);
  assign step = bus.mm[0] ? base - 16'h0001 : base + 16'h0001;

  // Pre-modify forms address the stepped value, post-modify the old one
  assign bus.addr = (bus.mode == isd_pkg::ISD_PM_IDX) ? sum :
                    (bus.mode == isd_pkg::ISD_PM_MOD && !bus.mm[1]) ? step :
                    base;
  assign new_val  = (bus.mode == isd_pkg::ISD_PM_ADD) ? sum :
                    (bus.mode == isd_pkg::ISD_PM_MOD) ? step : base;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ptr_reg[0] <= isd_pkg::ISD_PTR_RST;
      ptr_reg[1] <= isd_pkg::ISD_PTR_RST;
    end else if (bus.commit) begin
      ptr_reg[bus.sel] <= new_val;
    end
  end

  assign bus.ptr0 = ptr_reg[0];
  assign bus.ptr1 = ptr_reg[1];

endmodule

// ===== isd_decoder.sv
// Decoder and cycle sequencer for the control, inherent and indirect subset.
`timescale 1ns/1ps
module isd_decoder (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // Program memory
  input  wire logic [13:0] i_instr,
  output logic             o_fetch_strobe,
  output logic [14:0]      o_fetch_addr,
  // Core state
  input  wire logic [7:0]  i_accum,
  input  wire logic [6:0]  i_pclath,
  input  wire logic [14:0] i_stack_top,
  // Return stack
  output logic             o_push,
  output logic [14:0]      o_push_addr,
  output logic             o_pop,
  output logic             o_int_reenable,
  // Accumulator and zero flag
  output logic             o_accum_we,
  output logic [7:0]       o_accum_data,
  output logic             o_zero_we,
  output logic             o_zero,
  // Configuration writes
  output logic             o_option_we,
  output logic             o_dir_we,
  output logic [2:0]       o_dir_sel,
  output logic [7:0]       o_cfg_data,
  // Power and watchdog
  output logic             o_standby,
  output logic             o_wdt_clear,
  output logic             o_soft_reset,
  output logic             o_flag_we,
  output logic             o_watchdog_expiry_flag,
  output logic             o_powerdown_flag,
  // Data memory
  output logic             o_mem_re,
  output logic             o_mem_we,
  output logic [15:0]      o_mem_addr,
  output logic [7:0]       o_mem_wdata,
  input  wire logic [7:0]  i_mem_rdata,
  // Pointers and sequencer view
  output logic [15:0]      o_ptr0,
  output logic [15:0]      o_ptr1,
  output logic [1:0]       o_quarter,
  output logic             o_flush,
  output logic             o_stall,
  output logic             o_unknown_op
);

  isd_ptr_if pif ();

  isd_ptr_unit u_ptr (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .bus        (pif.unit)
  );

  logic [1:0]        q_reg;
  logic [1:0]        q_next;
  isd_pkg::isd_seq_e st_reg;
  isd_pkg::isd_seq_e st_next;
  logic [13:0]       ir_reg;
  logic [14:0]       pc_reg;
  logic [14:0]       pc_next;
  logic [14:0]       pc_inc;
  logic [14:0]       pc_target;

  // Decode of the held instruction word
  wire logic d_nop    = isd_pkg::isd_match(ir_reg, isd_pkg::OP_NOP, isd_pkg::M_EXACT);
  wire logic d_reset  = isd_pkg::isd_match(ir_reg, isd_pkg::OP_RESET, isd_pkg::M_EXACT);
  wire logic d_ret    = isd_pkg::isd_match(ir_reg, isd_pkg::OP_RETURN, isd_pkg::M_EXACT);
  wire logic d_interrupt_return = isd_pkg::isd_match(ir_reg, isd_pkg::OP_INTERRUPT_RETURN, isd_pkg::M_EXACT);
  wire logic d_accumulator_subroutine_call  = isd_pkg::isd_match(ir_reg, isd_pkg::OP_ACCUMULATOR_SUBROUTINE_CALL, isd_pkg::M_EXACT);
  wire logic d_brw    = isd_pkg::isd_match(ir_reg, isd_pkg::OP_BRW, isd_pkg::M_EXACT);
  wire logic d_option = isd_pkg::isd_match(ir_reg, isd_pkg::OP_OPTION, isd_pkg::M_EXACT);
  wire logic d_sleep  = isd_pkg::isd_match(ir_reg, isd_pkg::OP_SLEEP, isd_pkg::M_EXACT);
  wire logic d_watchdog_clear_op = isd_pkg::isd_match(ir_reg, isd_pkg::OP_WATCHDOG_CLEAR_OP, isd_pkg::M_EXACT);
  wire logic d_low3   = isd_pkg::isd_match(ir_reg, isd_pkg::OP_DIRECTION_LOAD_OP, isd_pkg::M_LOW3);
  wire logic d_mod_rd = isd_pkg::isd_match(ir_reg, isd_pkg::OP_MOD_RD, isd_pkg::M_LOW3);
  wire logic d_mod_wr = isd_pkg::isd_match(ir_reg, isd_pkg::OP_MOD_WR, isd_pkg::M_LOW3);
  wire logic d_bra    = isd_pkg::isd_match(ir_reg, isd_pkg::OP_BRA, isd_pkg::M_BRA);
  wire logic d_call   = isd_pkg::isd_match(ir_reg, isd_pkg::OP_CALL, isd_pkg::M_JMP);
  wire logic d_goto   = isd_pkg::isd_match(ir_reg, isd_pkg::OP_GOTO, isd_pkg::M_JMP);
  wire logic d_return_with_literal  = isd_pkg::isd_match(ir_reg, isd_pkg::OP_RETURN_WITH_LITERAL, isd_pkg::M_LIT8);
  wire logic d_addp   = isd_pkg::isd_match(ir_reg, isd_pkg::OP_ADD_PTR, isd_pkg::M_K6);
  wire logic d_idx_rd = isd_pkg::isd_match(ir_reg, isd_pkg::OP_IDX_RD, isd_pkg::M_K6);
  wire logic d_idx_wr = isd_pkg::isd_match(ir_reg, isd_pkg::OP_IDX_WR, isd_pkg::M_K6);

  // Exact words inside the direction range take priority over it
  wire logic d_direction_load_op = d_low3 & ~d_option & ~d_sleep & ~d_watchdog_clear_op;

  wire logic ind_rd = d_mod_rd | d_idx_rd;
  wire logic ind_wr = d_mod_wr | d_idx_wr;
  wire logic is_ind = ind_rd | ind_wr;
  wire logic is_mod = d_mod_rd | d_mod_wr;
  wire logic is_idx = d_idx_rd | d_idx_wr;

  wire logic is_ret_any = d_ret | d_interrupt_return | d_return_with_literal;
  wire logic is_call_any = d_call | d_accumulator_subroutine_call;

  // Everything that rewrites the program counter owns a flush cycle
  wire logic two_cycle = d_bra | d_brw | d_call | d_accumulator_subroutine_call | d_goto |
                         is_ret_any;

  wire logic known = d_nop | d_reset | d_option | d_sleep | d_watchdog_clear_op |
                     d_direction_load_op | is_ind | d_addp | two_cycle;

  // Sequencer phases
  wire logic q_first = (q_reg == isd_pkg::ISD_Q_FETCH);
  wire logic q_mem = (q_reg == isd_pkg::ISD_Q_MEM);
  wire logic q_last = (q_reg == isd_pkg::ISD_Q_LAST);
  wire logic in_exec = (st_reg == isd_pkg::ISD_EXEC);
  wire logic in_extra = (st_reg == isd_pkg::ISD_EXTRA);

  // Access beyond the low half of the pointer space costs a cycle
  wire logic need_extra = is_ind & pif.addr[15];

  // The cycle in which the held instruction takes effect
  wire logic act = (in_exec & ~need_extra) | in_extra;
  wire logic act_end = act & q_last;
  wire logic act_mem = act & q_mem;

  // Pointer unit control
  assign pif.sel = is_mod ? ir_reg[2] : ir_reg[6];
  assign pif.mm = ir_reg[1:0];
  assign pif.k6 = ir_reg[5:0];
  assign pif.mode = d_addp ? isd_pkg::ISD_PM_ADD :
                    is_mod ? isd_pkg::ISD_PM_MOD :
                    is_idx ? isd_pkg::ISD_PM_IDX :
                    isd_pkg::ISD_PM_NONE;
  // Indexed forms leave the pointer as it was
  assign pif.commit = act_end & (d_addp | is_mod);

  // Program counter targets
  assign pc_inc = pc_reg + 15'h0001;

  wire logic [14:0] tgt_bra = pc_inc + {{6{ir_reg[8]}}, ir_reg[8:0]};
  wire logic [14:0] tgt_brw = pc_inc + {7'h00, i_accum};
  wire logic [14:0] tgt_abs = {i_pclath[6:3], ir_reg[10:0]};
  wire logic [14:0] tgt_accumulator_subroutine_call = {i_pclath, i_accum};

  assign pc_target = d_bra ? tgt_bra :
                     d_brw ? tgt_brw :
                     (d_call | d_goto) ? tgt_abs :
                     d_accumulator_subroutine_call ? tgt_accumulator_subroutine_call :
                     is_ret_any ? i_stack_top :
                     pc_inc;

  assign pc_next = act_end ? pc_target : pc_reg;

  // Quarter counter: one instruction cycle per four clocks
  assign q_next = q_last ? isd_pkg::ISD_Q_FETCH : q_reg + 2'h1;

  always_comb begin
    st_next = st_reg;
    if (q_last) begin
      case (st_reg)
        isd_pkg::ISD_EXEC: begin
          if (need_extra) begin
            st_next = isd_pkg::ISD_EXTRA;
          end else if (two_cycle) begin
            st_next = isd_pkg::ISD_FLUSH;
          end else begin
            st_next = isd_pkg::ISD_EXEC;
          end
        end
        isd_pkg::ISD_FLUSH: st_next = isd_pkg::ISD_EXEC;
        isd_pkg::ISD_EXTRA: st_next = isd_pkg::ISD_EXEC;
        default:            st_next = isd_pkg::ISD_EXEC;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      q_reg  <= isd_pkg::ISD_Q_FETCH;
      st_reg <= isd_pkg::ISD_EXEC;
      pc_reg <= isd_pkg::ISD_PC_RST;
    end else begin
      q_reg  <= q_next;
      st_reg <= st_next;
      pc_reg <= pc_next;
    end
  end

  // The word is only taken at the start of a normal cycle; the flush
  // cycle keeps the old word but never acts on it
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ir_reg <= isd_pkg::OP_NOP;
    end else if (in_exec & q_first) begin
      ir_reg <= i_instr;
    end
  end

  // Control flow effects
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_push         <= 1'b0;
      o_push_addr    <= isd_pkg::ISD_PC_RST;
      o_pop          <= 1'b0;
      o_int_reenable <= 1'b0;
    end else begin
      o_push         <= act_end & is_call_any;
      o_pop          <= act_end & is_ret_any;
      o_int_reenable <= act_end & d_interrupt_return;
      if (act_end) begin
        o_push_addr <= pc_inc;
      end
    end
  end

  // Accumulator loads and zero flag
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_accum_we   <= 1'b0;
      o_accum_data <= 8'h00;
      o_zero_we    <= 1'b0;
      o_zero       <= 1'b0;
    end else begin
      o_accum_we <= act_end & (d_return_with_literal | ind_rd);
      o_zero_we  <= act_end & ind_rd;
      if (act_end) begin
        o_accum_data <= d_return_with_literal ? ir_reg[7:0] : i_mem_rdata;
        o_zero       <= (i_mem_rdata == 8'h00);
      end
    end
  end

  // Configuration register writes from the accumulator
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_option_we <= 1'b0;
      o_dir_we    <= 1'b0;
      o_dir_sel   <= 3'h0;
      o_cfg_data  <= 8'h00;
    end else begin
      o_option_we <= act_end & d_option;
      o_dir_we    <= act_end & d_direction_load_op;
      if (act_end) begin
        o_dir_sel  <= ir_reg[2:0];
        o_cfg_data <= i_accum;
      end
    end
  end

  // Power control and watchdog status
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_standby              <= 1'b0;
      o_wdt_clear            <= 1'b0;
      o_soft_reset           <= 1'b0;
      o_flag_we              <= 1'b0;
      o_watchdog_expiry_flag <= 1'b0;
      o_powerdown_flag       <= 1'b0;
    end else begin
      o_standby    <= act_end & d_sleep;
      o_wdt_clear  <= act_end & d_watchdog_clear_op;
      o_soft_reset <= act_end & d_reset;
      o_flag_we    <= act_end & (d_sleep | d_watchdog_clear_op);
      if (act_end & d_sleep) begin
        o_watchdog_expiry_flag <= isd_pkg::SLEEP_EXPIRY;
        o_powerdown_flag       <= isd_pkg::SLEEP_PD;
      end else if (act_end & d_watchdog_clear_op) begin
        o_watchdog_expiry_flag <= isd_pkg::WATCHDOG_CLEAR_OP_EXPIRY;
        o_powerdown_flag       <= isd_pkg::WATCHDOG_CLEAR_OP_PD;
      end
    end
  end

  // Data memory: request in the second quarter, data back by the last
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_mem_re    <= 1'b0;
      o_mem_we    <= 1'b0;
      o_mem_addr  <= isd_pkg::ISD_PTR_RST;
      o_mem_wdata <= 8'h00;
    end else begin
      o_mem_re <= act_mem & ind_rd;
      o_mem_we <= act_mem & ind_wr;
      if (act_mem & is_ind) begin
        o_mem_addr  <= pif.addr;
        o_mem_wdata <= i_accum;
      end
    end
  end

  // Unrecognised words run as single-cycle no-operations
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_unknown_op <= 1'b0;
    end else begin
      o_unknown_op <= act_end & ~known;
    end
  end

  assign o_fetch_strobe = in_exec & q_first;
  assign o_fetch_addr = pc_reg;
  assign o_ptr0 = pif.ptr0;
  assign o_ptr1 = pif.ptr1;
  assign o_quarter = q_reg;
  assign o_flush = (st_reg == isd_pkg::ISD_FLUSH);
  assign o_stall = in_extra;

endmodule

// ===== isd_checker.sv
// Concurrent checks on the decoder's ports, bound to its top module.
`timescale 1ns/1ps
module isd_checker (
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire logic [13:0] i_instr,
  input wire logic [7:0]  i_mem_rdata,
  input wire logic        o_fetch_strobe,
  input wire logic [14:0] o_fetch_addr,
  input wire logic        o_push,
  input wire logic [14:0] o_push_addr,
  input wire logic        o_pop,
  input wire logic        o_int_reenable,
  input wire logic        o_soft_reset,
  input wire logic        o_accum_we,
  input wire logic [7:0]  o_accum_data,
  input wire logic        o_zero_we,
  input wire logic        o_zero,
  input wire logic        o_mem_re,
  input wire logic        o_mem_we,
  input wire logic [15:0] o_mem_addr,
  input wire logic [15:0] o_ptr0,
  input wire logic [1:0]  o_quarter,
  input wire logic        o_flush,
  input wire logic        o_stall
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  wire two_cyc = (i_instr[13:2] == 12'h002) || (i_instr[13:12] == 2'b10) ||
                 (i_instr[13:9] == 5'b11001) || (i_instr[13:8] == 6'h34);
  wire one_cyc = (i_instr == 14'h0000) || (i_instr[13:6] == 8'hC4) ||
                 ((i_instr[13:3] == 11'h00C) && (i_instr[2:0] != 3'h3));

  chk_flush_len: assert property ($rose(o_flush) |-> o_flush [*4] ##1 !o_flush)
    else $error("flush cycle not one instruction cycle long");
  chk_tcy_quarters: assert property (o_quarter == 2'h0 |=> o_quarter == 2'h1 ##1
    o_quarter == 2'h2 ##1 o_quarter == 2'h3 ##1 o_quarter == 2'h0)
    else $error("instruction cycle is not four clocks");
  chk_ctrl_flush: assert property (o_fetch_strobe && two_cyc |-> ##4 o_flush)
    else $error("control operation without second cycle");
  chk_single_cycle: assert property (o_fetch_strobe && one_cyc |-> ##4 o_fetch_strobe)
    else $error("single-cycle operation took longer");
  chk_push_ret: assert property (o_push |-> o_push_addr == $past(o_fetch_addr, 4) + 15'h1)
    else $error("pushed return address wrong");
  chk_ptr_add: assert property ((o_fetch_strobe && i_instr[13:6] == 8'hC4) ##4 1'b1 |->
    o_ptr0 == $past(o_ptr0, 4) + {{10{$past(i_instr[5], 4)}}, $past(i_instr[5:0], 4)})
    else $error("pointer add result wrong");
  chk_stall_extra: assert property (o_mem_re || o_mem_we |-> o_stall == o_mem_addr[15])
    else $error("extra indirect cycle mismatch");
  chk_zero_read: assert property (o_zero_we |-> o_accum_we &&
    o_accum_data == $past(i_mem_rdata) && o_zero == ($past(i_mem_rdata) == 8'h00))
    else $error("indirect read result or zero flag wrong");

  cov_stall: cover property (o_stall && o_mem_re);
  cov_ret_int: cover property (o_pop && o_int_reenable);
  cov_soft_rst: cover property (o_soft_reset);
endmodule

bind isd_decoder isd_checker u_chk (.*);

// ===== isd_prog_mem.sv
// Program memory model answering the decoder's fetches.
`timescale 1ns/1ps
module isd_prog_mem (
  input  wire logic        i_core_clk,
  input  wire logic        i_fetch_strobe,
  input  wire logic [14:0] i_fetch_addr,
  output logic      [13:0] o_instr
);
  logic [13:0] mem [0:2047];
  initial o_instr = 14'h0000;
  // Outside the fetch quarter the word toggles so a late sample cannot pass
  always @(negedge i_core_clk) begin
    if (i_fetch_strobe) o_instr <= mem[i_fetch_addr[10:0]];
    else o_instr <= ~o_instr;
  end
endmodule

// ===== tb_instruction_subset_decoder.sv
// Self-checking bench for the instruction subset decoder.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected %0t got %h exp %h", $time, g, e); end end
module tb_instruction_subset_decoder;
  typedef struct packed {logic [3:0] k; logic [23:0] v;} isd_note_s;
  localparam logic [13:0] PROG [13] = '{14'h0062, 14'h0065, 14'h0063, 14'h0064, 14'h3120,
    14'h0010, 14'h315F, 14'h001F, 14'h3FF2, 14'h3F72, 14'h0002, 14'h2300, 14'h0009};
  logic        i_core_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [13:0] i_instr;
  logic [7:0]  i_accum = 8'h00;
  logic [6:0]  i_pclath = 7'h00;
  logic [14:0] i_stack_top = 15'h0500;
  logic [7:0]  i_mem_rdata = 8'h00;
  logic        o_fetch_strobe, o_push, o_pop, o_int_reenable, o_accum_we, o_zero_we, o_zero;
  logic        o_option_we, o_dir_we, o_standby, o_wdt_clear, o_soft_reset, o_flag_we;
  logic        o_watchdog_expiry_flag, o_powerdown_flag, o_mem_re, o_mem_we, o_flush;
  logic        o_stall, o_unknown_op;
  logic [14:0] o_fetch_addr, o_push_addr;
  logic [7:0]  o_accum_data, o_cfg_data, o_mem_wdata;
  logic [15:0] o_mem_addr, o_ptr0, o_ptr1;
  logic [2:0]  o_dir_sel;
  logic [1:0]  o_quarter;
  int          error_cnt = 0;
  int          num_checks = 0;
  bit          watching = 0;
  isd_note_s   exp_q[$];
  logic [14:0] stk[$];

  isd_decoder dut (.*);
  isd_prog_mem pm (.i_core_clk(i_core_clk), .i_fetch_strobe(o_fetch_strobe),
                   .i_fetch_addr(o_fetch_addr), .o_instr(i_instr));

  always #5 i_core_clk = ~i_core_clk;

  task close_out();
    if (error_cnt == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task note(input logic [3:0] k, input logic [23:0] v);
    exp_q.push_back({k, v});
  endtask

  task fa(input logic [14:0] a);
    note(4'h0, {9'h000, a});
  endtask

  task obs(input logic [3:0] k, input logic [23:0] v);
    isd_note_s e;
    if (exp_q.size() == 0) begin
      error_cnt++;
      $display("unexpected %0t extra event %h", $time, k);
    end else begin
      e = exp_q.pop_front();
      `CHK({k, v}, e)
    end
  endtask

  // Observer also plays the core's return stack and data memory.
  // It yields once so that the release step, which shares this edge with
  // the first fetch clock, has already raised watching.
  always @(negedge i_core_clk) begin
    #0;
    if (watching) begin
      if (o_mem_re) obs(4'h5, {8'h00, o_mem_addr});
      if (o_mem_we) obs(4'h6, {o_mem_addr, o_mem_wdata});
      if (o_accum_we) obs(4'h1, {14'h0, o_zero_we, o_zero_we & o_zero, o_accum_data});
      if (o_option_we) obs(4'h2, {16'h0, o_cfg_data});
      if (o_dir_we) obs(4'h3, {13'h0, o_dir_sel, o_cfg_data});
      if (o_flag_we)
        obs(4'h4, {20'h0, o_standby, o_wdt_clear, o_watchdog_expiry_flag, o_powerdown_flag});
      if (o_push) obs(4'h7, {9'h0, o_push_addr});
      if (o_pop) obs(4'h8, {23'h0, o_int_reenable});
      if (o_unknown_op) obs(4'h9, 24'h0);
      if (o_soft_reset) obs(4'hA, 24'h0);
      if (o_fetch_strobe) obs(4'h0, {9'h0, o_fetch_addr});
    end
    if (i_rst) stk.delete();
    if (o_push && !i_rst) stk.push_back(o_push_addr);
    if (o_pop && !i_rst && stk.size() > 0) void'(stk.pop_back());
    i_stack_top <= (stk.size() > 0) ? stk[$] : 15'h0500;
    i_mem_rdata <= o_mem_addr[7:0] + 8'hF0;
  end

  task run_prog(input logic [7:0] a);
    int n;
    pm.mem[11'(a)] = 14'h000B;
    pm.mem[11'(2 * a + 1)] = 14'h3205;
    pm.mem[11'(2 * a + 7)] = 14'h345A;
    @(negedge i_core_clk);
    i_rst <= 1'b1;
    i_accum <= a;
    repeat (10) @(negedge i_core_clk);
    fa(0); note(4'h2, a); fa(1); note(4'h3, {3'h5, a}); fa(2);
    note(4'h4, {1'b1, 1'b0, isd_pkg::SLEEP_EXPIRY, isd_pkg::SLEEP_PD}); fa(3);
    note(4'h4, {1'b0, 1'b1, isd_pkg::WATCHDOG_CLEAR_OP_EXPIRY, isd_pkg::WATCHDOG_CLEAR_OP_PD}); fa(4); fa(5);
    note(4'h5, 16'hFFE1); note(4'h1, {2'b10, 8'hD1}); fa(6); fa(7);
    note(4'h6, {16'h001F, a}); fa(8); note(4'h6, {16'h0010, a}); fa(9);
    note(4'h5, 16'h0010); note(4'h1, {2'b11, 8'h00}); fa(10); note(4'h9, 0); fa(11);
    note(4'h7, 12); fa(15'h300); note(4'h7, 15'h301); fa({7'h0, a});
    fa(2 * a + 1); fa(2 * a + 7); note(4'h1, {2'b00, 8'h5A}); note(4'h8, 0);
    fa(15'h301); fa(15'h400); note(4'h8, 0); fa(12); note(4'h8, 1);
    fa(15'h500); note(4'hA, 0); fa(15'h501);
    watching = 1;
    i_rst <= 1'b0;
    n = 0;
    while (exp_q.size() > 0 && n < 400) begin
      @(posedge i_core_clk);
      n++;
    end
    watching = 0;
    if (exp_q.size() > 0) begin
      error_cnt++;
      $display("unexpected %0t program stalled", $time);
      exp_q.delete();
    end
  endtask

  initial begin
    logic [31:0] s;
    s = 32'h7814;
    for (int i = 0; i < 13; i++) pm.mem[i] = PROG[i];
    pm.mem[15'h300] = 14'h000A;
    pm.mem[15'h301] = 14'h2C00;
    pm.mem[15'h400] = 14'h0008;
    pm.mem[15'h500] = 14'h0001;
    // Word after the soft reset is fetched before the run stops
    pm.mem[15'h501] = 14'h0000;
    repeat (4) begin
      s = xs(s);
      run_prog({2'b01, s[5:0]});
    end
    close_out();
  end

  initial begin
    #100000;
    error_cnt++;
    close_out();
  end
endmodule
